// *** src/gauge_i2c_pkg.sv ***
package gauge_i2c_pkg;

    // ************************************************************
    // Bus addressing
    // ************************************************************
    localparam logic [6:0] TARGET_ADDR  = 7'h55;
    localparam logic [7:0] ADDR_BYTE_WR = 8'hAA;
    localparam logic [7:0] ADDR_BYTE_RD = 8'hAB;
    localparam logic [6:0] PTR_RESET    = 7'h00;
    localparam logic [6:0] PTR_STEP     = 7'h01;
    localparam logic [6:0] PTR_PAIR     = 7'h02;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS        = 10;
    localparam int unsigned STUCK_BUS_TIMEOUT_US = 2000;
    localparam int unsigned STUCK_BUS_CYCLES     = STUCK_BUS_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned REFRESH_PERIOD_MS    = 1280;
    localparam int unsigned REFRESH_CYCLES       = (REFRESH_PERIOD_MS * 1000 / CLK_PERIOD_NS) * 1000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_ADDR   = 4'b0001,
        ST_CMD    = 4'b0010,
        ST_WDATA  = 4'b0011,
        ST_TX     = 4'b0100,
        ST_RACK   = 4'b0101,
        ST_ACK    = 4'b0110,
        ST_IGNORE = 4'b0111
    } eng_state_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
    } pins_in_t;

    typedef struct packed {
        logic       scl_o;
        logic       scl_oe_n;
        logic       sda_o;
        logic       sda_oe_n;
    } pins_out_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] rdata_odd;
        logic       read_only;
    } reg_rsp_t;

    typedef struct packed {
        logic       start;
        logic       stop;
        logic       stuck;
        logic       sleep;
        logic       refresh_tick;
    } watch_t;

    typedef struct packed {
        eng_state_t state;
        eng_state_t after;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [6:0] ptr;
        logic       rw;
        logic       wr_done;
        logic       mack;
        logic       pair_valid;
        logic [7:0] pair_byte;
        logic       sda_oe_n;
        logic       scl_q;
        reg_req_t   req;
    } eng_t;

    localparam eng_t ENG_RESET = '{
        state: ST_IDLE, after: ST_IDLE, cnt: 4'h0, shreg: 8'h00, ptr: PTR_RESET,
        rw: 1'b0, wr_done: 1'b0, mack: 1'b0, pair_valid: 1'b0, pair_byte: 8'h00,
        sda_oe_n: 1'b1, scl_q: 1'b1,
        req: '{addr: PTR_RESET, rd: 1'b0, wr: 1'b0, wdata: 8'h00}
    };

endpackage

// *** src/gauge_bus_watch.sv ***
`timescale 1ns/1ps

module gauge_bus_watch #(
    parameter int unsigned STUCK_CYCLES   = gauge_i2c_pkg::STUCK_BUS_CYCLES,
    parameter int unsigned REFRESH_CYCLES = gauge_i2c_pkg::REFRESH_CYCLES
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Bus lines
    input  wire gauge_i2c_pkg::pins_in_t pins_in,
    // Activity level from the gauge
    input  wire logic [7:0]             activity_level,
    input  wire logic [7:0]             activity_sleep_threshold,
    // Bus events and power state
    output gauge_i2c_pkg::watch_t       watch
);

    typedef struct packed {
        logic        scl_q;
        logic        sda_q;
        logic [31:0] low_cnt;
        logic [31:0] ref_cnt;
        gauge_i2c_pkg::watch_t ev;
    } watch_state_t;

    watch_state_t r_reg;
    watch_state_t r_next;

    // ************************************************************
    // Conditions, low counter, sleep and refresh
    // ************************************************************
    always_comb begin
        r_next = r_reg;
        r_next.scl_q = pins_in.scl;
        r_next.sda_q = pins_in.sda;
        // Start: SDA falls with SCL high; stop: SDA rises with SCL high
        r_next.ev.start = pins_in.scl & r_reg.scl_q & r_reg.sda_q & ~pins_in.sda;
        r_next.ev.stop  = pins_in.scl & r_reg.scl_q & ~r_reg.sda_q & pins_in.sda;
        // time any line held low without an edge
        if ((pins_in.scl != r_reg.scl_q) || (pins_in.sda != r_reg.sda_q) || (pins_in.scl && pins_in.sda)) begin
            r_next.low_cnt  = 32'h0000_0000;
            r_next.ev.stuck = 1'b0;
        end else if (r_reg.low_cnt >= 32'(STUCK_CYCLES - 1)) begin
            r_next.ev.stuck = 1'b1;
        end else begin
            r_next.low_cnt = r_reg.low_cnt + 32'h0000_0001;
        end
        // lines both high wake the device
        if (pins_in.scl && pins_in.sda) begin
            r_next.ev.sleep = 1'b0;
        // stuck bus with little activity sleeps
        end else if (r_reg.ev.stuck && (activity_level < activity_sleep_threshold)) begin
            r_next.ev.sleep = 1'b1;
        end
        r_next.ev.refresh_tick = 1'b0;
        if (r_reg.ref_cnt >= 32'(REFRESH_CYCLES - 1)) begin
            r_next.ref_cnt         = 32'h0000_0000;
            r_next.ev.refresh_tick = 1'b1;
        end else begin
            r_next.ref_cnt = r_reg.ref_cnt + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '{scl_q: 1'b1, sda_q: 1'b1, low_cnt: 32'h0000_0000, ref_cnt: 32'h0000_0000,
                       ev: '{start: 1'b0, stop: 1'b0, stuck: 1'b0, sleep: 1'b0, refresh_tick: 1'b0}};
        end else begin
            r_reg <= r_next;
        end
    end

    assign watch = r_reg.ev;

endmodule

// *** src/gauge_i2c_target_engine.sv ***
`timescale 1ns/1ps

module gauge_i2c_target_engine #(
    parameter int unsigned STUCK_CYCLES   = gauge_i2c_pkg::STUCK_BUS_CYCLES,
    parameter int unsigned REFRESH_CYCLES = gauge_i2c_pkg::REFRESH_CYCLES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Bus pins
    input  wire gauge_i2c_pkg::pins_in_t  pins_in,
    output gauge_i2c_pkg::pins_out_t      pins_out,
    // Register space access
    output gauge_i2c_pkg::reg_req_t       req,
    input  wire gauge_i2c_pkg::reg_rsp_t  rsp,
    // Activity and power
    input  wire logic [7:0]              activity_level,
    input  wire logic [7:0]              activity_sleep_threshold,
    output logic                         sleep,
    output logic                         refresh_tick
);

    gauge_i2c_pkg::eng_t   r_reg;
    gauge_i2c_pkg::eng_t   r_next;
    gauge_i2c_pkg::watch_t watch;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  byte_done;

    // ************************************************************
    // Line watcher
    // ************************************************************

    // Start, stop, stuck bus, sleep and refresh timing
    gauge_bus_watch #(
        .STUCK_CYCLES   (STUCK_CYCLES),
        .REFRESH_CYCLES (REFRESH_CYCLES)
    ) u_watch (
        .clk                      (clk),
        .rst                      (rst),
        .pins_in                  (pins_in),
        .activity_level           (activity_level),
        .activity_sleep_threshold (activity_sleep_threshold),
        .watch                    (watch)
    );

    // ************************************************************
    // Transmit byte loader
    // ************************************************************

    // Fetch next read byte, from pair latch or register space
    function automatic gauge_i2c_pkg::eng_t load_tx(input gauge_i2c_pkg::eng_t s,
                                                    input gauge_i2c_pkg::reg_rsp_t d);
        gauge_i2c_pkg::eng_t o;
        logic [7:0]          b;
        o = s;
        b = 8'h00;
        if (s.pair_valid) begin
            // odd byte only on continued read
            b            = s.pair_byte;
            o.pair_valid = 1'b0;
        end else begin
            b          = d.rdata;
            o.req.rd   = 1'b1;
            o.req.addr = s.ptr;
            if (!s.ptr[0]) begin
                // latch odd byte with even byte
                o.pair_byte  = d.rdata_odd;
                o.pair_valid = 1'b1;
                o.ptr        = s.ptr + gauge_i2c_pkg::PTR_PAIR;
            end else begin
                o.ptr = s.ptr + gauge_i2c_pkg::PTR_STEP;
            end
        end
        o.shreg    = {b[6:0], 1'b0};
        o.sda_oe_n = b[7];
        o.cnt      = 4'h1;
        o.state    = gauge_i2c_pkg::ST_TX;
        return o;
    endfunction

    // ************************************************************
    // Protocol engine
    // ************************************************************

    // SCL edges from the previous sample
    assign scl_rise  = pins_in.scl & ~r_reg.scl_q;
    assign scl_fall  = ~pins_in.scl & r_reg.scl_q;
    assign byte_done = (r_reg.cnt == gauge_i2c_pkg::BITS_PER_BYTE);

    // Next state of the whole engine
    always_comb begin
        r_next        = r_reg;
        r_next.scl_q  = pins_in.scl;
        r_next.req.rd = 1'b0;
        r_next.req.wr = 1'b0;
        if (watch.stuck) begin
            // free both lines on a stuck bus
            r_next.state      = gauge_i2c_pkg::ST_IGNORE;
            r_next.sda_oe_n   = 1'b1;
            r_next.pair_valid = 1'b0;
        end else if (watch.start) begin
            // every transfer opens with an address
            r_next.state      = gauge_i2c_pkg::ST_ADDR;
            r_next.cnt        = 4'h0;
            r_next.sda_oe_n   = 1'b1;
            r_next.pair_valid = 1'b0;
            r_next.wr_done    = 1'b0;
        end else if (watch.stop) begin
            // a stop drops the latched odd byte
            r_next.state      = gauge_i2c_pkg::ST_IDLE;
            r_next.sda_oe_n   = 1'b1;
            r_next.pair_valid = 1'b0;
        end else begin
            case (r_reg.state)
                gauge_i2c_pkg::ST_ADDR, gauge_i2c_pkg::ST_CMD, gauge_i2c_pkg::ST_WDATA: begin
                    if (scl_rise && !byte_done) begin
                        r_next.shreg = {r_reg.shreg[6:0], pins_in.sda};
                        r_next.cnt   = r_reg.cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        r_next.cnt   = 4'h0;
                        r_next.state = gauge_i2c_pkg::ST_ACK;
                        if (r_reg.state == gauge_i2c_pkg::ST_ADDR) begin
                            if (r_reg.shreg[7:1] == gauge_i2c_pkg::TARGET_ADDR) begin
                                r_next.sda_oe_n = 1'b0;
                                r_next.rw       = r_reg.shreg[0];
                                r_next.after    = r_reg.shreg[0] ? gauge_i2c_pkg::ST_TX : gauge_i2c_pkg::ST_CMD;
                            end else begin
                                // foreign address, stay off the bus
                                r_next.state = gauge_i2c_pkg::ST_IGNORE;
                            end
                        end else if (r_reg.state == gauge_i2c_pkg::ST_CMD) begin
                            if (r_reg.shreg[7]) begin
                                r_next.sda_oe_n = 1'b1;
                                r_next.after    = gauge_i2c_pkg::ST_IGNORE;
                            end else begin
                                r_next.ptr      = r_reg.shreg[6:0];
                                r_next.sda_oe_n = 1'b0;
                                r_next.wr_done  = 1'b0;
                                r_next.after    = gauge_i2c_pkg::ST_WDATA;
                            end
                        end else begin
                            r_next.after   = gauge_i2c_pkg::ST_WDATA;
                            r_next.wr_done = 1'b1;
                            if (!r_reg.wr_done && !rsp.read_only) begin
                                r_next.req.wr    = 1'b1;
                                r_next.req.addr  = r_reg.ptr;
                                r_next.req.wdata = r_reg.shreg;
                                r_next.ptr       = r_reg.ptr + gauge_i2c_pkg::PTR_STEP;
                                r_next.sda_oe_n  = 1'b0;
                            end else begin
                                r_next.sda_oe_n = 1'b1;
                            end
                        end
                    end
                end
                gauge_i2c_pkg::ST_ACK: begin
                    // Hold acknowledge through the ninth clock
                    if (scl_fall) begin
                        r_next.sda_oe_n = 1'b1;
                        if (r_reg.after == gauge_i2c_pkg::ST_TX) begin
                            r_next = load_tx(r_next, rsp);
                        end else begin
                            r_next.state = r_reg.after;
                            r_next.cnt   = 4'h0;
                        end
                    end
                end
                gauge_i2c_pkg::ST_TX: begin
                    // Shift read byte out on SCL falls
                    if (scl_fall) begin
                        if (byte_done) begin
                            r_next.sda_oe_n = 1'b1;
                            r_next.cnt      = 4'h0;
                            r_next.state    = gauge_i2c_pkg::ST_RACK;
                        end else begin
                            r_next.sda_oe_n = r_reg.shreg[7];
                            r_next.shreg    = {r_reg.shreg[6:0], 1'b0};
                            r_next.cnt      = r_reg.cnt + 4'h1;
                        end
                    end
                end
                gauge_i2c_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        r_next.mack = ~pins_in.sda;
                    end else if (scl_fall) begin
                        if (r_reg.mack) begin
                            r_next = load_tx(r_next, rsp);
                        end else begin
                            // master NACK drops the odd byte
                            r_next.state      = gauge_i2c_pkg::ST_IGNORE;
                            r_next.pair_valid = 1'b0;
                        end
                    end
                end
                gauge_i2c_pkg::ST_IDLE, gauge_i2c_pkg::ST_IGNORE: begin
                    r_next.sda_oe_n = 1'b1;
                end
                default: begin
                    r_next.state    = gauge_i2c_pkg::ST_IDLE;
                    r_next.sda_oe_n = 1'b1;
                end
            endcase
        end
        // Address output follows the pointer except on a strobe
        if (!r_next.req.wr && !r_next.req.rd) begin
            r_next.req.addr = r_next.ptr;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= gauge_i2c_pkg::ENG_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Open-drain pins: value low, enable active low; SCL never stretched
    assign pins_out.scl_o    = 1'b0;
    assign pins_out.scl_oe_n = 1'b1;
    assign pins_out.sda_o    = 1'b0;
    assign pins_out.sda_oe_n = r_reg.sda_oe_n;

    // Register access and power state
    assign req          = r_reg.req;
    assign sleep        = watch.sleep;
    assign refresh_tick = watch.refresh_tick;

endmodule

// *** verif/gauge_i2c_target_engine_props.sv ***
`timescale 1ns/1ps

module gauge_i2c_target_engine_props #(
    parameter int unsigned STUCK_CYCLES   = 50,
    parameter int unsigned REFRESH_CYCLES = 20
) (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Bus pins
    input wire gauge_i2c_pkg::pins_in_t  pins_in,
    input wire gauge_i2c_pkg::pins_out_t pins_out,
    // Register space access
    input wire gauge_i2c_pkg::reg_req_t  req,
    input wire gauge_i2c_pkg::reg_rsp_t  rsp,
    // Activity and power
    input wire logic [7:0]               activity_level,
    input wire logic [7:0]               activity_sleep_threshold,
    input wire logic                     sleep,
    input wire logic                     refresh_tick
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ************************************************************
    // Helper counters
    // ************************************************************
    gauge_i2c_pkg::pins_in_t pins_reg;
    int unsigned             quiet_reg;
    int unsigned             gap_reg;

    // Quiet cycles with a line low, cycles since last tick
    always_ff @(posedge clk) begin
        pins_reg <= pins_in;
        if (rst || pins_in != pins_reg || pins_in == 2'h3) begin
            quiet_reg <= '0;
        end else if (quiet_reg < 32'h0000_FFFF) begin
            quiet_reg <= quiet_reg + 1;
        end
        if (rst || refresh_tick) begin
            gap_reg <= '0;
        end else begin
            gap_reg <= gap_reg + 1;
        end
    end

    // ************************************************************
    // Sequences and assertions
    // ************************************************************
    // Both lines high for six samples
    sequence s_lines_idle;
        (pins_in == 2'h3) [*6];
    endsequence
    // Fetch at an even pointer
    sequence s_even_fetch;
        req.rd && !req.addr[0];
    endsequence

    chk_scl_never_held: assert property (pins_out.scl_oe_n)
        else $error("engine drives SCL");
    chk_stuck_release: assert property (quiet_reg > STUCK_CYCLES + 4 |-> pins_out.sda_oe_n)
        else $error("SDA held after stuck timeout");
    chk_ro_no_write: assert property (req.wr |-> !rsp.read_only)
        else $error("write strobe to read-only byte");
    chk_wr_ptr_step: assert property (req.wr |=> req.addr == $past(req.addr) + gauge_i2c_pkg::PTR_STEP)
        else $error("pointer not stepped after write");
    chk_even_pair_step: assert property (s_even_fetch |=> req.addr == $past(req.addr) + gauge_i2c_pkg::PTR_PAIR)
        else $error("pointer not stepped by two");
    chk_sda_low_scl: assert property ($fell(pins_out.sda_oe_n) |-> !pins_in.scl)
        else $error("SDA pulled while SCL high");
    chk_sleep_cause: assert property ($rose(sleep) |-> $past(activity_level) < $past(activity_sleep_threshold))
        else $error("sleep with activity above threshold");
    chk_wake_idle: assert property (s_lines_idle |-> !sleep)
        else $error("asleep with both lines high");
    chk_refresh_gap: assert property (refresh_tick |-> gap_reg >= REFRESH_CYCLES - 1)
        else $error("refresh ticks too close");
endmodule

bind gauge_i2c_target_engine gauge_i2c_target_engine_props #(
    .STUCK_CYCLES  (STUCK_CYCLES),
    .REFRESH_CYCLES(REFRESH_CYCLES)
) u_props (
    .clk(clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out), .req(req), .rsp(rsp),
    .activity_level(activity_level), .activity_sleep_threshold(activity_sleep_threshold),
    .sleep(sleep), .refresh_tick(refresh_tick)
);

// *** verif/gauge_host_model.sv ***
`timescale 1ns/1ps

module gauge_host_model (
    // Clock
    input wire logic clk,
    // Data line level on the bus
    input wire logic sda_w,
    // Open-drain pulls, low while pulling down
    output logic     scl_oe_n,
    output logic     sda_oe_n
);
    int half = 6;

    // Lines released at power-up
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start_c();
        @(posedge clk);
        sda_oe_n <= 1'b1;
        wait_cyc(half);
        scl_oe_n <= 1'b1;
        wait_cyc(half);
        sda_oe_n <= 1'b0;
        wait_cyc(half);
        scl_oe_n <= 1'b0;
        wait_cyc(half);
    endtask

    // Stop: data rises while clock high
    task automatic stop_c();
        @(posedge clk);
        sda_oe_n <= 1'b0;
        wait_cyc(half);
        scl_oe_n <= 1'b1;
        wait_cyc(half);
        sda_oe_n <= 1'b1;
        wait_cyc(half);
    endtask

    task automatic idle_c();
        @(posedge clk);
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
        wait_cyc(half);
    endtask

    // One clock pulse; data set while clock low
    task automatic bit_c(input logic b, output logic r);
        sda_oe_n <= b;
        wait_cyc(half);
        scl_oe_n <= 1'b1;
        wait_cyc(half);
        r = sda_w;
        scl_oe_n <= 1'b0;
        wait_cyc(2);
    endtask

    // Eight data bits, then the acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_c(tx[i], rx[i]);
        end
        bit_c(mack, nak);
    endtask
endmodule

// *** verif/gauge_i2c_target_engine_test.sv ***
`timescale 1ns/1ps

module gauge_i2c_target_engine_test;
    localparam int unsigned STUCK   = 50;
    localparam int unsigned REFRESH = 20;

    logic                     clk;
    logic                     rst;
    logic                     ext_scl_low;
    logic [7:0]               activity_level;
    logic [7:0]               threshold;
    logic [7:0]               mem [128];
    logic                     m_scl_oe_n;
    logic                     m_sda_oe_n;
    logic                     scl_w;
    logic                     sda_w;
    logic                     sleep;
    logic                     refresh_tick;
    int                       err_total;
    int                       compares;
    int                       drv_cnt;
    gauge_i2c_pkg::pins_in_t  pins_in;
    gauge_i2c_pkg::pins_out_t pins_out;
    gauge_i2c_pkg::reg_req_t  req;
    gauge_i2c_pkg::reg_rsp_t  rsp;

    // Wired-AND bus with pull-ups, lower register half read-only
    assign scl_w   = m_scl_oe_n & (pins_out.scl_oe_n | pins_out.scl_o) & ~ext_scl_low;
    assign sda_w   = m_sda_oe_n & (pins_out.sda_oe_n | pins_out.sda_o);
    assign pins_in = '{scl: scl_w, sda: sda_w};
    assign rsp     = '{rdata: mem[req.addr], rdata_odd: mem[{req.addr[6:1], 1'b1}], read_only: ~req.addr[6]};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    gauge_i2c_target_engine #(.STUCK_CYCLES(STUCK), .REFRESH_CYCLES(REFRESH)) u_gauge_i2c_target_engine (
        .clk(clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out), .req(req), .rsp(rsp),
        .activity_level(activity_level), .activity_sleep_threshold(threshold),
        .sleep(sleep), .refresh_tick(refresh_tick));
    gauge_host_model u_gauge_host_model (
        .clk(clk), .sda_w(sda_w), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));

    // Gauge memory and engine drive monitor
    always @(posedge clk) begin
        if (req.wr === 1'b1) begin
            mem[req.addr] <= req.wdata;
        end
        if (pins_out.sda_oe_n === 1'b0) begin
            drv_cnt <= drv_cnt + 1;
        end
    end

    function automatic logic [7:0] pat(input logic [6:0] a);
        return {1'b0, a} ^ 8'hA5;
    endfunction

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tx(input logic [7:0] b, input logic exp_nak);
        logic [7:0] d;
        logic       n;
        u_gauge_host_model.xfer(b, 1'b1, d, n);
        chk(n === exp_nak, "acknowledge");
    endtask

    task automatic rx(input logic mnak, input logic [7:0] exp);
        logic [7:0] d;
        logic       n;
        u_gauge_host_model.xfer(8'hFF, mnak, d, n);
        chk(d === exp, "read data");
    endtask

    // Address for write, then the command byte
    task automatic point(input logic [6:0] a);
        u_gauge_host_model.start_c();
        tx(gauge_i2c_pkg::ADDR_BYTE_WR, 1'b0);
        tx({1'b0, a}, 1'b0);
    endtask

    task automatic quick(input logic [7:0] exp);
        u_gauge_host_model.start_c();
        tx(gauge_i2c_pkg::ADDR_BYTE_RD, 1'b0);
        rx(1'b1, exp);
        u_gauge_host_model.stop_c();
    endtask

    task automatic pair_rd(input logic [6:0] a, input logic mnak, input logic [7:0] exp);
        point(a);
        u_gauge_host_model.start_c();
        tx(gauge_i2c_pkg::ADDR_BYTE_RD, 1'b0);
        rx(mnak, exp);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_write();
        point(7'h41);
        tx(8'h3C, 1'b0);
        tx(8'h77, 1'b1);
        u_gauge_host_model.stop_c();
        chk(mem[7'h41] === 8'h3C, "byte not stored");
        chk(mem[7'h42] === pat(7'h42), "extra stored");
        quick(pat(7'h42));
        point(7'h05);
        tx(8'h11, 1'b1);
        u_gauge_host_model.stop_c();
        chk(mem[7'h05] === pat(7'h05), "read-only hit");
        u_gauge_host_model.start_c();
        tx(gauge_i2c_pkg::ADDR_BYTE_WR, 1'b0);
        tx(8'h85, 1'b1);
        u_gauge_host_model.stop_c();
        quick(pat(7'h05));
    endtask

    task automatic t_pairs();
        pair_rd(7'h10, 1'b0, pat(7'h10));
        mem[7'h11] <= 8'h00;
        rx(1'b1, pat(7'h11));
        u_gauge_host_model.stop_c();
        mem[7'h11] <= pat(7'h11);
        quick(pat(7'h12));
        pair_rd(7'h20, 1'b1, pat(7'h20));
        u_gauge_host_model.stop_c();
        quick(pat(7'h22));
        pair_rd(7'h23, 1'b1, pat(7'h23));
        u_gauge_host_model.stop_c();
        quick(pat(7'h24));
        u_gauge_host_model.half = 15;
        pair_rd(7'h7E, 1'b0, pat(7'h7E));
        rx(1'b0, pat(7'h7F));
        rx(1'b1, pat(7'h00));
        u_gauge_host_model.stop_c();
        u_gauge_host_model.half = 6;
    endtask

    task automatic t_foreign();
        drv_cnt = 0;
        u_gauge_host_model.start_c();
        tx(8'hA8, 1'b1);
        tx(8'h30, 1'b1);
        u_gauge_host_model.start_c();
        tx(8'hAD, 1'b1);
        u_gauge_host_model.stop_c();
        chk(drv_cnt === 0, "drove foreign");
    endtask

    task automatic t_tick();
        int n;
        n = 0;
        while (refresh_tick !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (refresh_tick !== 1'b1 && n < 100);
        chk(n == REFRESH, "tick spacing");
    endtask

    task automatic t_sleep();
        @(posedge clk);
        ext_scl_low <= 1'b1;
        repeat (2 * STUCK + 20) @(negedge clk);
        chk(sleep === 1'b0, "slept while busy");
        @(posedge clk);
        activity_level <= 8'h00;
        repeat (8) @(negedge clk);
        chk(sleep === 1'b1, "no sleep");
        @(posedge clk);
        ext_scl_low <= 1'b0;
        repeat (8) @(negedge clk);
        chk(sleep === 1'b0, "no wake");
    endtask

    task automatic t_stuck();
        logic [7:0] d;
        u_gauge_host_model.start_c();
        for (int i = 7; i >= 0; i--) begin
            u_gauge_host_model.bit_c(gauge_i2c_pkg::ADDR_BYTE_WR[i], d[i]);
        end
        repeat (3) @(negedge clk);
        chk(pins_out.sda_oe_n === 1'b0, "no ack");
        repeat (STUCK + 10) @(negedge clk);
        chk(pins_out.sda_oe_n === 1'b1, "SDA kept held");
        chk(sleep === 1'b1, "no sleep");
        u_gauge_host_model.idle_c();
        repeat (8) @(negedge clk);
        chk(sleep === 1'b0, "no wake");
        u_gauge_host_model.start_c();
        tx(gauge_i2c_pkg::ADDR_BYTE_WR, 1'b0);
        u_gauge_host_model.stop_c();
    endtask

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rst            = 1'b1;
        ext_scl_low    = 1'b0;
        activity_level = 8'h09;
        threshold      = 8'h05;
        err_total      = 0;
        compares       = 0;
        drv_cnt        = 0;
        for (int i = 0; i < 128; i++) begin
            mem[i] = pat(7'(i));
        end
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_write();
        t_pairs();
        t_foreign();
        t_tick();
        t_sleep();
        t_stuck();
        tally_and_finish();
    end
endmodule
